// *** rtl/plss_defines.svh ***
// offsets, field positions, reset values and timing figures of the led source select block
`ifndef PLSS_DEFINES_SVH
`define PLSS_DEFINES_SVH

// ********************************************************
// register indices (byte address is four times the index)
// ********************************************************
`define PLSS_GAIN_IDX 8'h13
`define PLSS_LED_IDX 8'h17
`define PLSS_XOVER_IDX 8'h18
`define PLSS_STAT_IDX 8'h19
`define PLSS_IDX_HI 9
`define PLSS_IDX_LO 2
`define PLSS_WORD_SIZE 3'h2

// ********************************************************
// reset values and write masks
// ********************************************************
`define PLSS_GAIN_RST 16'h4000
`define PLSS_LED_RST 16'h0010
`define PLSS_XOVER_RST 16'h00c0
`define PLSS_LED_WMASK 16'h00ff

// ********************************************************
// led configuration fields
// ********************************************************
`define PLSS_FIRST_SEL_HI 7
`define PLSS_FIRST_SEL_LO 4
`define PLSS_SECOND_SEL_HI 3
`define PLSS_SECOND_SEL_LO 0

// ********************************************************
// status register bit positions
// ********************************************************
`define PLSS_STAT_FIRST_BIT 0
`define PLSS_STAT_SECOND_BIT 1
`define PLSS_STAT_LINK_BIT 2
`define PLSS_STAT_ACT_BIT 3
`define PLSS_STAT_S100_BIT 4
`define PLSS_STAT_S10_BIT 5
`define PLSS_STAT_FDX_BIT 6
`define PLSS_STAT_FIRST_BAD_BIT 7
`define PLSS_STAT_SECOND_BAD_BIT 8

// ********************************************************
// timing
// ********************************************************
`define PLSS_CLK_MHZ 200
`define PLSS_HOLD_MS 50
`define PLSS_BLINK_MS 25

`endif

// *** rtl/plss_pkg.sv ***
// types shared by the led source select block
package plss_pkg;

  // ********************************************************
  // led source codes
  // ********************************************************
  typedef enum logic [3:0] {
    PLSS_SRC_LINK = 4'h0,
    PLSS_SRC_ACT = 4'h1,
    PLSS_SRC_100 = 4'h5,
    PLSS_SRC_10 = 4'h6,
    PLSS_SRC_FDX = 4'h7,
    PLSS_SRC_LINK_BLINK = 4'h8
  } plss_src_type;

  // ********************************************************
  // activity stretcher states, one-hot
  // ********************************************************
  typedef enum logic [1:0] {
    PLSS_BL_IDLE = 2'b01,
    PLSS_BL_HOLD = 2'b10
  } plss_blink_state_type;

  // ********************************************************
  // live phy status levels
  // ********************************************************
  typedef struct packed {
    logic link_good;
    logic rx_activity;
    logic tx_activity;
    logic speed_100;
    logic speed_10;
    logic full_duplex;
  } plss_phy_status_type;

endpackage

// *** rtl/plss_act_blink.sv ***
// activity stretcher and blink phase generator
`timescale 1ns/1ps
`default_nettype none
module plss_act_blink #(
  parameter int unsigned HOLD_CYCLES = 32'd10,
  parameter int unsigned BLINK_CYCLES = 32'd5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic activity_in,
  output logic act_level_out,
  output logic blink_phase_out
);

  plss_pkg::plss_blink_state_type state_q;
  plss_pkg::plss_blink_state_type state_d;
  logic [31:0] hold_q;
  logic [31:0] hold_d;
  logic [31:0] blink_q;
  logic [31:0] blink_d;
  logic phase_q;
  logic phase_d;

  wire blink_wrap = (blink_q == 32'h0);

  // short frames are invisible on a lamp, so activity is held for a visible time
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    blink_d = blink_q;
    phase_d = phase_q;
    case (state_q)
      plss_pkg::PLSS_BL_IDLE: begin
        if (activity_in) begin
          state_d = plss_pkg::PLSS_BL_HOLD;
          hold_d = HOLD_CYCLES - 32'h1;
          blink_d = BLINK_CYCLES - 32'h1;
          phase_d = 1'b1;
        end
      end
      plss_pkg::PLSS_BL_HOLD: begin
        blink_d = blink_wrap ? BLINK_CYCLES - 32'h1 : blink_q - 32'h1;
        phase_d = blink_wrap ? ~phase_q : phase_q;
        if (activity_in) begin
          hold_d = HOLD_CYCLES - 32'h1;
        end else if (hold_q == 32'h0) begin
          state_d = plss_pkg::PLSS_BL_IDLE;
          phase_d = 1'b0;
        end else begin
          hold_d = hold_q - 32'h1;
        end
      end
      default: begin
        state_d = plss_pkg::PLSS_BL_IDLE;
        phase_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= plss_pkg::PLSS_BL_IDLE;
      hold_q <= 32'h0;
      blink_q <= 32'h0;
      phase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      blink_q <= blink_d;
      phase_q <= phase_d;
    end
  end

  assign act_level_out = (state_q == plss_pkg::PLSS_BL_HOLD);
  assign blink_phase_out = phase_q;

endmodule
`default_nettype wire

// *** rtl/plss_led_mux.sv ***
// one led output: source selection from a four-bit code
`timescale 1ns/1ps
`default_nettype none
module plss_led_mux (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] select_in,
  input wire plss_pkg::plss_phy_status_type status_in,
  input wire logic act_level_in,
  input wire logic blink_phase_in,
  output logic led_out,
  output logic select_bad_out
);

  logic src_d;
  logic bad_d;
  logic led_q;

  always_comb begin
    src_d = 1'b0;
    bad_d = 1'b0;
    case (select_in)
      plss_pkg::PLSS_SRC_LINK: src_d = status_in.link_good;
      plss_pkg::PLSS_SRC_ACT: src_d = act_level_in;
      plss_pkg::PLSS_SRC_100: src_d = status_in.speed_100;
      plss_pkg::PLSS_SRC_10: src_d = status_in.speed_10;
      plss_pkg::PLSS_SRC_FDX: src_d = status_in.full_duplex;
      plss_pkg::PLSS_SRC_LINK_BLINK: src_d = status_in.link_good & ~blink_phase_in;
      default: begin
        // reserved codes keep the lamp dark
        src_d = 1'b0;
        bad_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      led_q <= 1'b0;
    end else begin
      led_q <= src_d;
    end
  end

  assign led_out = led_q;
  assign select_bad_out = bad_d;

endmodule
`default_nettype wire

// *** rtl/plss_top.sv ***
// led source select block with its phy management registers behind an ahb-lite slave
//
// Function
// - first led follows the source chosen by config bits 7:4
// - second led follows the source chosen by config bits 3:0
// - code zero shows link good; reset choice of the second led
// - code one shows rx or tx activity; reset choice of the first led
// - codes five, six, seven show 100 mbit, 10 mbit, full duplex
// - code eight lights on link and blinks on activity
// - led config at index 0x17 resets to 0x0010
// - gain control register at index 0x13, read-write, resets to 0x4000
// - crossover control register at index 0x18, read-write, resets to 0x00c0
`timescale 1ns/1ps
`default_nettype none
`include "plss_defines.svh"
module plss_top #(
  parameter int unsigned HOLD_CYCLES = `PLSS_HOLD_MS * 1000 * `PLSS_CLK_MHZ,
  parameter int unsigned BLINK_CYCLES = `PLSS_BLINK_MS * 1000 * `PLSS_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // phy side
  input wire plss_pkg::plss_phy_status_type phy_status_in,
  output logic first_indicator_output_out,
  output logic second_indicator_output_out,
  output logic [15:0] gain_control_out,
  output logic [15:0] crossover_control_out
);

  // ********************************************************
  // address decode
  // ********************************************************

  function automatic logic idx_hit(
    input logic [31:0] addr,
    input logic [7:0] idx
  );
    logic upper_zero;
    logic lower_zero;
    upper_zero = (addr[31:`PLSS_IDX_HI+1] == '0);
    lower_zero = (addr[`PLSS_IDX_LO-1:0] == '0);
    return upper_zero && lower_zero && (addr[`PLSS_IDX_HI:`PLSS_IDX_LO] == idx);
  endfunction

  wire addr_phase = hsel_in & hready_in & htrans_in[1];
  wire word_size = (hsize_in == `PLSS_WORD_SIZE);
  wire rd_take = addr_phase & ~hwrite_in;
  // writes of a part word are dropped rather than merged into half a register
  wire wr_take = addr_phase & hwrite_in & word_size;

  wire hit_gain = idx_hit(haddr_in, `PLSS_GAIN_IDX);
  wire hit_led = idx_hit(haddr_in, `PLSS_LED_IDX);
  wire hit_xover = idx_hit(haddr_in, `PLSS_XOVER_IDX);
  wire hit_stat = idx_hit(haddr_in, `PLSS_STAT_IDX);

  // ********************************************************
  // data phase bookkeeping
  // ********************************************************

  logic wr_gain_q;
  logic wr_led_q;
  logic wr_xover_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_gain_q <= 1'b0;
      wr_led_q <= 1'b0;
      wr_xover_q <= 1'b0;
    end else if (hready_in) begin
      wr_gain_q <= wr_take & hit_gain;
      wr_led_q <= wr_take & hit_led;
      wr_xover_q <= wr_take & hit_xover;
    end
  end

  // ********************************************************
  // registers
  // ********************************************************

  logic [15:0] gain_q;
  logic [15:0] gain_d;
  logic [15:0] led_q;
  logic [15:0] led_d;
  logic [15:0] xover_q;
  logic [15:0] xover_d;

  assign gain_d = wr_gain_q ? hwdata_in[15:0] : gain_q;
  // upper config bits are not stored, so they always read back zero
  assign led_d = wr_led_q ? (hwdata_in[15:0] & `PLSS_LED_WMASK) : led_q;
  assign xover_d = wr_xover_q ? hwdata_in[15:0] : xover_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gain_q <= `PLSS_GAIN_RST;
      led_q <= `PLSS_LED_RST;
      xover_q <= `PLSS_XOVER_RST;
    end else begin
      gain_q <= gain_d;
      led_q <= led_d;
      xover_q <= xover_d;
    end
  end

  // ********************************************************
  // selector fields
  // ********************************************************

  wire [3:0] first_sel = led_q[`PLSS_FIRST_SEL_HI:`PLSS_FIRST_SEL_LO];
  wire [3:0] second_sel = led_q[`PLSS_SECOND_SEL_HI:`PLSS_SECOND_SEL_LO];

  // ********************************************************
  // activity stretch and blink
  // ********************************************************

  logic act_level;
  logic blink_phase;

  wire any_activity = phy_status_in.rx_activity | phy_status_in.tx_activity;

  plss_act_blink #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_blink (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .activity_in(any_activity),
    .act_level_out(act_level),
    .blink_phase_out(blink_phase)
  );

  // ********************************************************
  // led source multiplexers
  // ********************************************************

  logic first_led;
  logic second_led;
  logic first_bad;
  logic second_bad;

  plss_led_mux u_first_mux (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .select_in(first_sel),
    .status_in(phy_status_in),
    .act_level_in(act_level),
    .blink_phase_in(blink_phase),
    .led_out(first_led),
    .select_bad_out(first_bad)
  );

  plss_led_mux u_second_mux (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .select_in(second_sel),
    .status_in(phy_status_in),
    .act_level_in(act_level),
    .blink_phase_in(blink_phase),
    .led_out(second_led),
    .select_bad_out(second_bad)
  );

  // ********************************************************
  // status word
  // ********************************************************

  logic [31:0] stat_word;

  always_comb begin
    stat_word = 32'h0;
    stat_word[`PLSS_STAT_FIRST_BIT] = first_led;
    stat_word[`PLSS_STAT_SECOND_BIT] = second_led;
    stat_word[`PLSS_STAT_LINK_BIT] = phy_status_in.link_good;
    stat_word[`PLSS_STAT_ACT_BIT] = act_level;
    stat_word[`PLSS_STAT_S100_BIT] = phy_status_in.speed_100;
    stat_word[`PLSS_STAT_S10_BIT] = phy_status_in.speed_10;
    stat_word[`PLSS_STAT_FDX_BIT] = phy_status_in.full_duplex;
    stat_word[`PLSS_STAT_FIRST_BAD_BIT] = first_bad;
    stat_word[`PLSS_STAT_SECOND_BAD_BIT] = second_bad;
  end

  // ********************************************************
  // read data
  // ********************************************************

  // reads look at the next values so a read right behind a write sees the new data
  wire [31:0] rd_gain = hit_gain ? {16'h0, gain_d} : 32'h0;
  wire [31:0] rd_led = hit_led ? {16'h0, led_d} : 32'h0;
  wire [31:0] rd_xover = hit_xover ? {16'h0, xover_d} : 32'h0;
  wire [31:0] rd_stat = hit_stat ? stat_word : 32'h0;
  wire [31:0] rd_value = rd_gain | rd_led | rd_xover | rd_stat;

  logic [31:0] hrdata_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_q <= 32'h0;
    end else if (hready_in) begin
      hrdata_q <= rd_take ? rd_value : 32'h0;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************

  // every access completes without wait states, so the bus never stalls here
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;

  assign first_indicator_output_out = first_led;
  assign second_indicator_output_out = second_led;

  assign gain_control_out = gain_q;
  assign crossover_control_out = xover_q;

endmodule
`default_nettype wire

// *** testbench/plss_top_properties.sv ***
// concurrent checks on the ports of the led source select block
`timescale 1ns/1ps
`default_nettype none
module plss_top_checker #(
  parameter int unsigned HOLD_CYCLES = 32'd40,
  parameter int unsigned BLINK_CYCLES = 32'd8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire plss_pkg::plss_phy_status_type phy_status_in,
  input wire logic first_indicator_output_out,
  input wire logic second_indicator_output_out,
  input wire logic [15:0] gain_control_out,
  input wire logic [15:0] crossover_control_out
);
  // ********************************************************
  // shadow of the selector fields, rebuilt from bus writes
  // ********************************************************
  logic [7:0] cfg_q;
  logic [2:0] wr_q;
  wire take_wr = hsel_in & hready_in & htrans_in[1] & hwrite_in & (hsize_in == 3'h2);
  wire [3:0] sel1 = cfg_q[7:4];
  wire [3:0] sel0 = cfg_q[3:0];
  wire lamp1 = first_indicator_output_out;
  wire lamp0 = second_indicator_output_out;
  // cycles since the last rx or tx activity, saturating so a long idle stretch stays large
  logic [31:0] quiet_q;
  wire link = phy_status_in.link_good;
  wire s100 = phy_status_in.speed_100;
  wire s10 = phy_status_in.speed_10;
  wire act = phy_status_in.rx_activity | phy_status_in.tx_activity;
  wire [15:0] wd_lo = hwdata_in[15:0];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_q <= 3'h0;
      cfg_q <= 8'h10;
    end else begin
      wr_q[2] <= take_wr & (haddr_in == 32'h0000004c);
      wr_q[1] <= take_wr & (haddr_in == 32'h0000005c);
      wr_q[0] <= take_wr & (haddr_in == 32'h00000060);
      if (wr_q[1]) begin
        cfg_q <= hwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      quiet_q <= 32'h0;
    end else if (act) begin
      quiet_q <= 32'h0;
    end else if (quiet_q != 32'hffffffff) begin
      quiet_q <= quiet_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence act_seen_s;
    sel1 == 4'h1 && act ##1 sel1 == 4'h1;
  endsequence

  first_link_a: assert property (
    !$past(rst_in) && $past(sel1) == 4'h0 |-> lamp1 == $past(link)) else $error("lamp1 link");
  second_link_a: assert property (
    !$past(rst_in) && $past(sel0) == 4'h0 |-> lamp0 == $past(link)) else $error("lamp0 link");
  fast_mode_a: assert property (
    !$past(rst_in) && $past(sel1) == 4'h5 |-> lamp1 == $past(s100)) else $error("lamp1 100");
  slow_mode_a: assert property (
    !$past(rst_in) && $past(sel0) == 4'h6 |-> lamp0 == $past(s10)) else $error("lamp0 10");
  act_lit_a: assert property (act_seen_s |=> lamp1) else $error("lamp1 activity");
  act_quiet_a: assert property (
    $past(sel1) == 4'h1 && quiet_q > HOLD_CYCLES + 32'h2 |-> !lamp1) else $error("lamp1 held");
  blink_dark_a: assert property (
    $past(sel0) == 4'h8 && !$past(link) |-> !lamp0) else $error("lamp0 no link");
  reserved_dark_a: assert property (
    ($past(sel0) inside {[4'h2:4'h4], [4'h9:4'hf]}) |-> !lamp0) else $error("lamp0 reserved");
  regs_reset_a: assert property ($past(rst_in) |->
    gain_control_out == 16'h4000 && crossover_control_out == 16'h00c0) else $error("reset");
  gain_write_a: assert property (
    wr_q[2] |=> gain_control_out == $past(wd_lo)) else $error("gain write");
  xover_write_a: assert property (
    wr_q[0] |=> crossover_control_out == $past(wd_lo)) else $error("crossover write");
endmodule

bind plss_top plss_top_checker #(.HOLD_CYCLES(HOLD_CYCLES), .BLINK_CYCLES(BLINK_CYCLES))
  u_checker (.*);
`default_nettype wire

// *** testbench/plss_led_board.sv ***
// board status lamps lit by the two indicator outputs
`timescale 1ns/1ps
`default_nettype none
module plss_led_board (
  input wire logic first_drive_in,
  input wire logic second_drive_in,
  output logic first_lit_out,
  output logic second_lit_out
);
  // lamps follow the pins directly; the board adds no latching or stretching
  assign first_lit_out = first_drive_in;
  assign second_lit_out = second_drive_in;
endmodule
`default_nettype wire

// *** testbench/plss_top_bench.sv ***
// self-checking bench for the led source select block
`timescale 1ns/1ps
`default_nettype none
module plss_top_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] st = 6'h0;
  logic hready, hresp, ind1, ind0, lit1, lit0;
  logic [31:0] hrdata, rd;
  logic [15:0] gain, xover;
  int err_total = 0;
  int check_count = 0;

  plss_top #(.HOLD_CYCLES(40), .BLINK_CYCLES(8)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .phy_status_in(st), .first_indicator_output_out(ind1),
    .second_indicator_output_out(ind0), .gain_control_out(gain),
    .crossover_control_out(xover));
  plss_led_board u_board (.first_drive_in(ind1), .second_drive_in(ind0),
    .first_lit_out(lit1), .second_lit_out(lit0));

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  // ********************************************************
  // bus access and comparison
  // ********************************************************
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("read", exp, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  function automatic logic lexp(input logic [3:0] c, input logic [5:0] s);
    case (c)
      4'h0: return s[5];
      4'h5: return s[2];
      4'h6: return s[1];
      4'h7: return s[0];
      4'h8: return s[5];
      default: return 1'b0;
    endcase
  endfunction

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdc(32'h4c, 32'h4000);
    rdc(32'h5c, 32'h0010);
    rdc(32'h60, 32'h00c0);
    chk("gain", 32'h4000, {16'h0, gain});
    bus(1'b1, 32'h4c, 32'h0000a5c3);
    bus(1'b1, 32'h60, 32'h00001234);
    rdc(32'h4c, 32'h0000a5c3);
    rdc(32'h60, 32'h00001234);
    chk("xover", 32'h1234, {16'h0, xover});
    bus(1'b1, 32'h68, 32'h0000ffff);
    rdc(32'h68, 32'h0);
    // idle activity here, so code one stays dark and code eight shows link only
    for (int c = 0; c < 16; c++) begin
      for (int p = 0; p < 2; p++) begin
        st <= p ? 6'b000010 : 6'b100101;
        bus(1'b0, 32'h5c, 32'h0);
        bus(1'b1, 32'h5c, {rd[31:8], c[3:0], c[3:0] + 4'h3});
        repeat (2) @(posedge clk_in);
        chk("first", {31'h0, lexp(c[3:0], st)}, {31'h0, lit1});
        chk("second", {31'h0, lexp(c[3:0] + 4'h3, st)}, {31'h0, lit0});
      end
    end
    // last pass leaves both selectors reserved and only the 10 mbit level up
    rdc(32'h64, 32'h000001a0);
    bus(1'b1, 32'h5c, 32'h00000018);
    for (int i = 0; i < 2; i++) begin
      st <= i ? 6'b101000 : 6'b110000;
      @(posedge clk_in);
      st <= 6'b100000;
      repeat (3) @(posedge clk_in);
      chk("act lit", 32'h1, {31'h0, lit1});
      chk("blink dark", 32'h0, {31'h0, lit0});
      repeat (60) @(posedge clk_in);
      chk("act idle", 32'h0, {31'h0, lit1});
      chk("link lit", 32'h1, {31'h0, lit0});
    end
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdc(32'h5c, 32'h0010);
    rdc(32'h4c, 32'h4000);
    rdc(32'h64, 32'h00000006);
    finish_test();
  end
endmodule
`default_nettype wire
